// *** shared/acsf_consts.svh ***
// What this block does
// - Other channel result read keeps data-ready raise
// - Completion stores both results, raises data-ready
// - Completion with data-ready set flags general overrun
// - Status read clears general overrun unless new
// - Status read never blocks general overrun update
// - Result read cannot hide general overrun
// - Completion over pending flag sets channel overrun
// - Result or last-result read clears channel flag
// - Status read clears channel overruns unless new
// - Disabled mid-conversion channel never flags completion
// - Result read clears only its channel
// - Sleep request waits for end of the conversion sequence
// - Only last-result read clears data-ready
`ifndef ACSF_CONSTS_SVH
`define ACSF_CONSTS_SVH

// Register byte offsets.
`define ACSF_CTRL_ADDR 12'h000
`define ACSF_MODE_ADDR 12'h004
`define ACSF_CHEN_ADDR 12'h010
`define ACSF_CHDIS_ADDR 12'h014
`define ACSF_CHSR_ADDR 12'h018
`define ACSF_STAT_ADDR 12'h01C
`define ACSF_IMR_ADDR 12'h02C
`define ACSF_LAST_ADDR 12'h020
`define ACSF_RES0_ADDR 12'h030

// Field positions.
`define ACSF_CTRL_START 1
`define ACSF_MODE_SLEEP 5
`define ACSF_STAT_DATA_READY_FLAG 16
`define ACSF_STAT_GOVR 17
`define ACSF_STAT_SLEEP 18
`define ACSF_STAT_OVR_LSB 8

// Reset values and widths.
`define ACSF_NCH 4
`define ACSF_DW 10
`define ACSF_ZERO32 32'h00000000
`define ACSF_CONV_CYCLES 8'h0B

`endif

// *** shared/acsf_pkg.sv ***
`default_nettype none
package acsf_pkg;
    // Converter sequencing states.
    typedef enum logic [1:0] {
        ACSF_IDLE = 2'b00,
        ACSF_CONV = 2'b01,
        ACSF_SLEEP = 2'b10
    } acsf_state_t;
    // One completed conversion as presented to the flag logic.
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [9:0] data;
    } acsf_done_t;
endpackage
`default_nettype wire

// *** rtl/acsf_chan_flags.sv ***
`include "acsf_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// Per-channel end-of-conversion and overrun flags.
// ----------------------------------------------------------------
module acsf_chan_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic done_here,
    input wire logic rd_clear,
    input wire logic stat_rd,
    output logic eoc,
    output logic ovr
);
    logic eoc_r, eoc_nxt; // End-of-conversion flag.
    logic ovr_r, ovr_nxt; // Overrun flag.

    // Set wins over clear for both flags.
    always_comb begin
        eoc_nxt = eoc_r;
        ovr_nxt = ovr_r;
        if (rd_clear) begin
            eoc_nxt = 1'b0;
        end
        if (stat_rd) begin
            ovr_nxt = 1'b0;
        end
        if (done_here) begin
            eoc_nxt = 1'b1;
            if (eoc_r) begin
                ovr_nxt = 1'b1;
            end
        end
    end

    // Registers the flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            eoc_r <= eoc_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    assign eoc = eoc_r;
    assign ovr = ovr_r;
endmodule // acsf_chan_flags
`default_nettype wire

// *** rtl/acsf_result_reg.sv ***
`include "acsf_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// One stored conversion result.
// ----------------------------------------------------------------
module acsf_result_reg (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [`ACSF_DW-1:0] din,
    output logic [`ACSF_DW-1:0] dout
);
    logic [`ACSF_DW-1:0] val_r, val_nxt; // Stored result.

    // Takes a new result on load.
    always_comb begin
        val_nxt = load ? din : val_r;
    end

    // Registers the result.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_r <= '0;
        end else begin
            val_r <= val_nxt;
        end
    end

    assign dout = val_r;
endmodule // acsf_result_reg
`default_nettype wire

// *** rtl/acsf_top.sv ***
`include "acsf_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// Converter status-flag block with APB register access.
// The analog converter is outside: conv_result is sampled at the
// end of each conversion window counted here.
// ----------------------------------------------------------------
module acsf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`ACSF_DW-1:0] conv_result,
    output logic conv_busy,
    output logic irq
);
    localparam int NCH = `ACSF_NCH;

    // ------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------
    logic acc; // Access phase, always answered in one cycle.
    logic wr; // Write taking effect this edge.
    logic rd; // Read taking effect this edge.
    logic hit_res; // Address falls on a channel result.
    logic [1:0] res_idx; // Channel of the result addressed.
    logic mapped; // Address is one of ours.
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign hit_res = (paddr >= `ACSF_RES0_ADDR) &&
                     (paddr < (`ACSF_RES0_ADDR + 12'h010)) &&
                     (paddr[1:0] == 2'b00);
    assign res_idx = paddr[3:2];
    assign mapped = hit_res || paddr == `ACSF_CTRL_ADDR ||
                    paddr == `ACSF_MODE_ADDR ||
                    paddr == `ACSF_CHEN_ADDR ||
                    paddr == `ACSF_CHDIS_ADDR ||
                    paddr == `ACSF_CHSR_ADDR ||
                    paddr == `ACSF_STAT_ADDR ||
                    paddr == `ACSF_IMR_ADDR ||
                    paddr == `ACSF_LAST_ADDR;

    logic stat_rd; // Status register read.
    logic last_rd; // Last-result register read.
    assign stat_rd = rd && paddr == `ACSF_STAT_ADDR;
    assign last_rd = rd && paddr == `ACSF_LAST_ADDR;

    // ------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------
    logic [NCH-1:0] chen_r, chen_nxt; // Channel enables.
    logic sleep_r, sleep_nxt; // Sleep setting.
    logic [31:0] imr_r, imr_nxt; // Interrupt mask.
    logic start_wr; // Start bit written.

    assign start_wr = wr && paddr == `ACSF_CTRL_ADDR &&
                      pwdata[`ACSF_CTRL_START];

    // Computes enable, sleep and mask updates.
    always_comb begin
        chen_nxt = chen_r;
        sleep_nxt = sleep_r;
        imr_nxt = imr_r;
        if (wr && paddr == `ACSF_CHEN_ADDR) begin
            chen_nxt = chen_r | pwdata[NCH-1:0];
        end
        if (wr && paddr == `ACSF_CHDIS_ADDR) begin
            chen_nxt = chen_r & ~pwdata[NCH-1:0];
        end
        if (wr && paddr == `ACSF_MODE_ADDR) begin
            sleep_nxt = pwdata[`ACSF_MODE_SLEEP];
        end
        if (wr && paddr == `ACSF_IMR_ADDR) begin
            imr_nxt = pwdata;
        end
    end

    // Registers the configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chen_r <= '0;
            sleep_r <= 1'b0;
            imr_r <= `ACSF_ZERO32;
        end else begin
            chen_r <= chen_nxt;
            sleep_r <= sleep_nxt;
            imr_r <= imr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer.
    // ------------------------------------------------------------
    acsf_pkg::acsf_state_t st_r, st_nxt; // Sequencer state.
    logic [7:0] cnt_r, cnt_nxt; // Cycles left in conversion.
    logic [1:0] ch_r, ch_nxt; // Channel being converted.
    logic [NCH-1:0] pend_r, pend_nxt; // Channels still to convert.
    logic [1:0] first_ch; // Lowest pending channel.
    acsf_pkg::acsf_done_t done; // Completion this cycle.

    // Picks the lowest set bit of a channel set.
    function automatic logic [1:0] lowest(input logic [NCH-1:0] m);
        logic [1:0] r;
        r = 2'b00;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    assign first_ch = lowest(pend_r);

    // Steps through enabled channels; sleep waits for the sequence to end.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ch_nxt = ch_r;
        pend_nxt = pend_r & chen_nxt;
        done = '0;
        unique case (st_r)
            acsf_pkg::ACSF_IDLE, acsf_pkg::ACSF_SLEEP: begin
                if (start_wr && chen_r != '0) begin
                    pend_nxt = chen_r;
                    ch_nxt = lowest(chen_r);
                    cnt_nxt = `ACSF_CONV_CYCLES;
                    st_nxt = acsf_pkg::ACSF_CONV;
                end
            end
            acsf_pkg::ACSF_CONV: begin
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    // A channel disabled mid-conversion gives no result.
                    done.valid = chen_r[ch_r] & chen_nxt[ch_r];
                    done.chan = ch_r;
                    done.data = conv_result;
                    pend_nxt = pend_r & chen_nxt &
                               ~(NCH'(1) << ch_r);
                    if (pend_nxt != '0) begin
                        ch_nxt = lowest(pend_nxt);
                        cnt_nxt = `ACSF_CONV_CYCLES;
                    end else if (sleep_r) begin
                        st_nxt = acsf_pkg::ACSF_SLEEP;
                    end else begin
                        st_nxt = acsf_pkg::ACSF_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = acsf_pkg::ACSF_IDLE;
            end
        endcase
    end

    // Registers the sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= acsf_pkg::ACSF_IDLE;
            cnt_r <= 8'h00;
            ch_r <= 2'b00;
            pend_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ch_r <= ch_nxt;
            pend_r <= pend_nxt;
        end
    end

    // ------------------------------------------------------------
    // Results and flags.
    // ------------------------------------------------------------
    logic [`ACSF_DW-1:0] res [NCH]; // Per-channel results.
    logic [`ACSF_DW-1:0] last_r, last_nxt; // Last-converted result.
    logic [1:0] last_ch_r, last_ch_nxt; // Channel of last result.
    logic [NCH-1:0] eoc, ovr; // Per-channel flags.
    logic data_ready_flag_r, data_ready_flag_nxt; // Data-ready flag.
    logic govr_r, govr_nxt; // General-overrun flag.

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            logic hit; // Completion on this channel.
            logic clr; // Read that clears this channel's flag.
            assign hit = done.valid && done.chan == 2'(g);
            assign clr = (rd && hit_res && res_idx == 2'(g)) ||
                         (last_rd && last_ch_r == 2'(g));
            acsf_result_reg u_res (
                .pclk(pclk),
                .presetn(presetn),
                .load(hit),
                .din(done.data),
                .dout(res[g])
            );
            acsf_chan_flags u_flags (
                .pclk(pclk),
                .presetn(presetn),
                .done_here(hit),
                .rd_clear(clr),
                .stat_rd(stat_rd),
                .eoc(eoc[g]),
                .ovr(ovr[g])
            );
        end
    endgenerate

    // Global flags: each completion is judged on its own, so reads
    // and disables elsewhere never mask it, and set beats clear.
    always_comb begin
        last_nxt = last_r;
        last_ch_nxt = last_ch_r;
        data_ready_flag_nxt = data_ready_flag_r;
        govr_nxt = govr_r;
        if (last_rd) begin
            data_ready_flag_nxt = 1'b0;
        end
        if (stat_rd) begin
            govr_nxt = 1'b0;
        end
        if (done.valid) begin
            last_nxt = done.data;
            last_ch_nxt = done.chan;
            data_ready_flag_nxt = 1'b1;
            if (data_ready_flag_r) begin
                govr_nxt = 1'b1;
            end
        end
    end

    // Registers the global flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_r <= '0;
            last_ch_r <= 2'b00;
            data_ready_flag_r <= 1'b0;
            govr_r <= 1'b0;
        end else begin
            last_r <= last_nxt;
            last_ch_r <= last_ch_nxt;
            data_ready_flag_r <= data_ready_flag_nxt;
            govr_r <= govr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data, answer and interrupt.
    // ------------------------------------------------------------
    logic [31:0] status; // Status word.
    logic [31:0] rdata_nxt; // Read data for this access.
    logic [31:0] prdata_r; // Registered read data.
    logic pready_r, pslverr_r, irq_r, busy_r; // Output flops.

    assign status = {13'h0000, sleep_q(st_r), govr_r, data_ready_flag_r,
                     4'h0, ovr, 4'h0, eoc};

    // Flags the sleep state in the status word.
    function automatic logic sleep_q(input acsf_pkg::acsf_state_t s);
        return s == acsf_pkg::ACSF_SLEEP;
    endfunction

    // Selects read data.
    always_comb begin
        rdata_nxt = `ACSF_ZERO32;
        if (hit_res) begin
            rdata_nxt = {22'h000000, res[res_idx]};
        end else begin
            unique case (paddr)
                `ACSF_MODE_ADDR: rdata_nxt[`ACSF_MODE_SLEEP] = sleep_r;
                `ACSF_CHSR_ADDR: rdata_nxt = {28'h0000000, chen_r};
                `ACSF_STAT_ADDR: rdata_nxt = status;
                `ACSF_IMR_ADDR: rdata_nxt = imr_r;
                `ACSF_LAST_ADDR: rdata_nxt = {20'h00000, 2'b00,
                                              last_r};
                default: rdata_nxt = `ACSF_ZERO32;
            endcase
        end
    end

    // Answers in the setup cycle's following edge: pready is high
    // during the whole access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= `ACSF_ZERO32;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            prdata_r <= (psel && !penable && !pwrite) ? rdata_nxt
                                                      : prdata_r;
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && !mapped;
            irq_r <= (status_nxt() & imr_r) != `ACSF_ZERO32;
            busy_r <= st_nxt == acsf_pkg::ACSF_CONV;
        end
    end

    // Next-cycle view of the interrupt-capable status bits.
    function automatic logic [31:0] status_nxt();
        return {14'h0000, govr_nxt, data_ready_flag_nxt, 16'h0000};
    endfunction

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign conv_busy = busy_r;
endmodule // acsf_top
`default_nettype wire

// *** verification/acsf_top_props.sv ***
`include "acsf_consts.svh"
`default_nettype none
// ------------------------------------------------
// Port-level checks of the flag block.
// ------------------------------------------------
module acsf_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`ACSF_DW-1:0] conv_result,
    input wire logic conv_busy,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A read finishing at this edge while no conversion can complete.
    logic acc;
    assign acc = psel && penable && pready && !pwrite && !conv_busy;
    // The access phase always answers at once.
    property p_rdy;
        psel && !penable |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready missing");
    // The answer lasts one cycle only.
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready stuck");
    // A refused read returns zero.
    property p_err;
        pslverr && !pwrite |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad refused read");
    // An address with no register is refused.
    property p_unmap;
        psel && !penable && paddr == 12'h008 |=> pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("no refusal");
    // Two status reads with no completion between: overruns gone.
    property p_sclr;
        acc && paddr == `ACSF_STAT_ADDR ##3 acc && paddr == `ACSF_STAT_ADDR
            |-> !prdata[17] && prdata[11:8] == 4'h0;
    endproperty
    a_sclr: assert property (p_sclr) else $error("overrun kept");
    // A channel result read leaves data-ready set.
    property p_keep;
        acc && paddr == `ACSF_STAT_ADDR && prdata[16]
            ##3 acc && paddr == `ACSF_RES0_ADDR
            ##3 acc && paddr == `ACSF_STAT_ADDR |-> prdata[16];
    endproperty
    a_keep: assert property (p_keep) else $error("ready lost");
    // A last-result read clears data-ready.
    property p_last;
        acc && paddr == `ACSF_LAST_ADDR ##3 acc && paddr == `ACSF_STAT_ADDR
            |-> !prdata[16];
    endproperty
    a_last: assert property (p_last) else $error("ready kept");
    // A channel result read clears its own flag.
    property p_own;
        acc && paddr == `ACSF_RES0_ADDR ##3 acc && paddr == `ACSF_STAT_ADDR
            |-> !prdata[0];
    endproperty
    a_own: assert property (p_own) else $error("flag kept");
    // The neighbour's flag is untouched by that read.
    property p_other;
        acc && paddr == `ACSF_STAT_ADDR ##3 acc && paddr == `ACSF_RES0_ADDR
            ##3 acc && paddr == `ACSF_STAT_ADDR
            |-> prdata[1] == $past(prdata[1], 6);
    endproperty
    a_other: assert property (p_other) else $error("flag changed");
    // Main scenarios reached.
    c_govr: cover property (acc && prdata[17]);
    c_err: cover property (pslverr);
    c_irq: cover property (irq);
endmodule // acsf_top_props
bind acsf_top acsf_top_props i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_result(conv_result), .conv_busy(conv_busy), .irq(irq));
`default_nettype wire

// *** verification/adc_conversion_status_flags_tb.sv ***
`include "acsf_consts.svh"
`default_nettype none
// ------------------------------------------------
// Self-checking bench of the flag block.
// ------------------------------------------------
module adc_conversion_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic conv_busy, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [`ACSF_DW-1:0] conv_result;
    int checks, mismatches;
    localparam logic [11:0] ad_stat = `ACSF_STAT_ADDR;
    localparam logic [11:0] ad_ctrl = `ACSF_CTRL_ADDR;
    localparam logic [11:0] ad_res0 = `ACSF_RES0_ADDR;
    localparam logic [11:0] ad_last = `ACSF_LAST_ADDR;
    acsf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_result(conv_result),
        .conv_busy(conv_busy), .irq(irq));
    // Clock of 4 ns period.
    always #2 pclk = ~pclk;
    // Compares one value and counts it.
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; holds it until pready is seen high.
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reads the status word and compares it.
    task automatic sr(logic [31:0] e);
        apb(1'b0, ad_stat, 32'h0);
        chk("status", rdat, e);
    endtask
    // Starts a sequence and waits for its end under a bound.
    task automatic go;
        int n;
        apb(1'b1, ad_ctrl, 32'h2);
        n = 0;
        while (conv_busy !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        while (conv_busy !== 1'b0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // Cleared state and refused address.
    task automatic t_reset;
        sr(32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped data", rdat, 32'h0);
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        $display("test reset done");
    endtask
    // One channel: store, flags, clears, interrupt on ready.
    task automatic t_single;
        conv_result <= 10'h2A5;
        apb(1'b1, `ACSF_CHEN_ADDR, 32'h1);
        apb(1'b1, `ACSF_IMR_ADDR, 32'h00010000);
        go;
        sr(32'h00010001);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b0, ad_res0, 32'h0);
        chk("result", rdat, 32'h2A5);
        sr(32'h00010000);
        apb(1'b0, ad_last, 32'h0);
        chk("last", {22'h0, rdat[9:0]}, 32'h2A5);
        sr(32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test single done");
    endtask
    // Two unread conversions: both overruns, then a status read.
    task automatic t_ovr;
        apb(1'b1, `ACSF_IMR_ADDR, 32'h00020000);
        go;
        go;
        @(posedge pclk);
        chk("irq", {31'h0, irq}, 32'h1);
        sr(32'h00030101);
        sr(32'h00010001);
        // The interrupt flop takes the cleared flag at the read's edge.
        @(posedge pclk);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b0, ad_last, 32'h0);
        $display("test overrun done");
    endtask
    // Two channels: a result read clears its own flag only; the second
    // completion finds data-ready still set and flags general overrun.
    task automatic t_two;
        conv_result <= 10'h155;
        apb(1'b1, `ACSF_CHEN_ADDR, 32'h3);
        go;
        sr(32'h00030003);
        apb(1'b0, ad_res0, 32'h0);
        chk("result", rdat, 32'h155);
        sr(32'h00010002);
        apb(1'b0, ad_last, 32'h0);
        sr(32'h0);
        $display("test two done");
    endtask
    // Channel 1 disabled inside its 12-cycle window never flags.
    task automatic t_dis;
        int n;
        apb(1'b1, ad_ctrl, 32'h2);
        repeat (14) @(posedge pclk);
        apb(1'b1, `ACSF_CHDIS_ADDR, 32'h2);
        n = 0;
        while (conv_busy !== 1'b0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        sr(32'h00010001);
        apb(1'b0, ad_last, 32'h0);
        $display("test disable done");
    endtask
    // Sleep is taken only after the next conversion ends.
    task automatic t_sleep;
        apb(1'b1, `ACSF_MODE_ADDR, 32'h20);
        sr(32'h0);
        go;
        sr(32'h00050001);
        $display("test sleep done");
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        finish_test;
    end
    // Main sequence.
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        conv_result = 10'h0;
        checks = 0;
        mismatches = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_single;
        t_ovr;
        t_two;
        t_dis;
        t_sleep;
        finish_test;
    end
endmodule // adc_conversion_status_flags_tb
`default_nettype wire
